// ### include/ucrm_pkg.sv
// Constants, field layouts and carrier types of the channel register map
package ucrm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_DATA   = 5'h00; // Holding / divisor low
	localparam logic [4:0] OFS_IE     = 5'h01; // Interrupt enable / divisor high
	localparam logic [4:0] OFS_ISRC   = 5'h02; // Interrupt source / fifo control
	localparam logic [4:0] OFS_LINE   = 5'h03; // Line control
	localparam logic [4:0] OFS_MODEM  = 5'h04; // Modem control
	localparam logic [4:0] OFS_LSTAT  = 5'h05; // Line status
	localparam logic [4:0] OFS_MSTAT  = 5'h06; // Modem status / turnaround
	localparam logic [4:0] OFS_SCR    = 5'h07; // Scratch byte
	localparam logic [4:0] OFS_FEAT   = 5'h08; // Feature control
	localparam logic [4:0] OFS_ENH    = 5'h09; // Enhanced function
	localparam logic [4:0] OFS_TXLV   = 5'h0a; // Tx level / tx trigger
	localparam logic [4:0] OFS_RXLV   = 5'h0b; // Rx level / rx trigger
	localparam logic [4:0] OFS_FLOW0  = 5'h0c; // Flags / pause char first
	localparam logic [4:0] OFS_FLOW1  = 5'h0d; // Pause char second
	localparam logic [4:0] OFS_FLOW2  = 5'h0e; // Resume char first
	localparam logic [4:0] OFS_FLOW3  = 5'h0f; // Resume char second
	localparam logic [4:0] OFS_EVT    = 5'h10; // Event status, write one to clear
	localparam logic [4:0] OFS_MSK    = 5'h11; // Event mask

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int         LC_DIV_BIT = 7;      // Divisor access bit
	localparam int         EF_EN_BIT  = 4;      // Enhanced enable bit
	localparam logic [7:0] IE_EXT     = 8'he0;  // Gated interrupt enable bits
	localparam logic [7:0] IS_EXT     = 8'h30;  // Gated interrupt source bits
	localparam logic [7:0] FC_EXT     = 8'h30;  // Gated fifo control bits
	localparam logic [7:0] MC_EXT     = 8'he4;  // Gated modem control bits
	localparam int         MC_LOOP    = 4;      // Internal loopback bit
	localparam int         MC_GOA     = 2;      // General out a position
	localparam int         MC_GOB     = 3;      // General out b position
	localparam int         FL_PAUSE   = 0;      // Pause char seen flag
	localparam int         FL_RESUME  = 1;      // Resume char seen flag
	localparam int         EV_W       = 4;      // Event bit count
	localparam int         EV_PAUSE   = 0;      // Pause char seen event
	localparam int         EV_RESUME  = 1;      // Resume char seen event
	localparam int         EV_TXLOAD  = 2;      // Tx holding loaded event
	localparam int         EV_DIV     = 3;      // Divisor changed event

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE   = 8'h00;  // All stored bytes
	localparam logic [3:0] RST_NIB    = 4'h0;   // Turnaround delay
	localparam logic [EV_W-1:0] RST_EV = 4'h0;  // Events and mask

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] rx_char;       // Received character
		logic [7:0] int_source;    // Interrupt source from core
		logic [7:0] line_status;   // Line status from core
		logic [7:0] modem_status;  // Modem status from core
		logic [7:0] tx_level;      // Tx fifo fill level
		logic [7:0] rx_level;      // Rx fifo fill level
		logic       xon_seen;      // Resume char detected pulse
		logic       xoff_seen;     // Pause char detected pulse
	} ucrm_core_t;

	typedef struct packed {
		logic [15:0] divisor;            // Baud divisor
		logic [7:0]  interrupt_enable;   // Effective enables
		logic [7:0]  fifo_control;       // Effective fifo control
		logic [7:0]  line_control;       // Line control
		logic [7:0]  modem_control;      // Effective modem control
		logic [3:0]  turnaround;         // Half duplex delay
		logic [7:0]  feature_control;    // Feature control
		logic [7:0]  enhanced_function;  // Enhanced function
		logic [7:0]  tx_trigger;         // Tx trigger level
		logic [7:0]  rx_trigger;         // Rx trigger level
		logic [7:0]  pause_first;        // Pause char first
		logic [7:0]  pause_second;       // Pause char second
		logic [7:0]  resume_first;       // Resume char first
		logic [7:0]  resume_second;      // Resume char second
		logic [7:0]  tx_char;            // Tx holding byte
	} ucrm_cfg_t;

endpackage

// ### hdl/ucrm_regs.sv
// Per-channel register map of the quad serial port
`timescale 1ns/1ps
// What this block does
// [RQ1] Divisor access maps offsets 0,1 to divisor
// [RQ2] Otherwise offset 0 holding, 1 interrupt enable
// [RQ3] Extended fields writable and effective only when enabled; a stored out a still reaches loop_general in loopback while disabled
// [RQ4] Gated fields: enables, source, fifo, modem, delay
// [RQ5] General outputs drive no pin
// [RQ6] General outputs stored, used in loopback; out a is stored only while extended fields are enabled
// [RQ7] Flag read: resume bit1, pause bit0, clears
// [RQ8] Writes 0xc-0xf load flow characters
// [RQ9] Offset 0xa: tx level read, trigger write
// [RQ10] Offset 0xb: rx level read, trigger write
// [RQ11] Offset 6 write stores delay nibble
// [RQ12] Scratch byte stores and returns value
// [RQ13] Software clears divisor access after programming
module ucrm_regs #(
	parameter int ADDR_W = 5 // Register address width
) (
	input  wire logic              clk,          // Device clock
	input  wire logic              rstn,         // Async reset, active low
	input  wire logic [ADDR_W-1:0] addr,         // Register address
	input  wire logic [7:0]        wdata,        // Write data
	input  wire logic              wr,           // Write strobe
	input  wire logic              rd,           // Read strobe
	output logic [7:0]             rdata,        // Read data, cycle after rd
	input  wire ucrm_pkg::ucrm_core_t core,      // Core status inputs
	output ucrm_pkg::ucrm_cfg_t    cfg,          // Configuration to core
	output logic                   rx_pop,       // Rx holding read pulse
	output logic                   tx_load,      // Tx holding write pulse
	output logic [1:0]             loop_general, // General outs into loopback
	output logic                   irq           // Level interrupt
);
	import ucrm_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] div_low;    // Divisor low byte
		logic [7:0] div_high;   // Divisor high byte
		logic [7:0] int_en;     // Stored interrupt enable
		logic [7:0] fifo_ctl;   // Stored fifo control
		logic [7:0] line_ctl;   // Line control
		logic [7:0] modem_ctl;  // Stored modem control
		logic [3:0] delay;      // Turnaround delay
		logic [7:0] scratch;    // Scratch byte
		logic [7:0] feat;       // Feature control
		logic [7:0] enh;        // Enhanced function
		logic [7:0] tx_trg;     // Tx trigger
		logic [7:0] rx_trg;     // Rx trigger
		logic [7:0] pause1;     // Pause char first
		logic [7:0] pause2;     // Pause char second
		logic [7:0] resume1;    // Resume char first
		logic [7:0] resume2;    // Resume char second
		logic [7:0] tx_hold;    // Tx holding byte
		logic [1:0] flags;      // Flow char seen flags
		logic [EV_W-1:0] evt;   // Sticky events
		logic [EV_W-1:0] msk;   // Event mask
		logic [7:0] rdata;      // Read data register
	} ucrm_state_t;

	ucrm_state_t st;       // Registered state
	ucrm_state_t next_st;  // Next state
	logic        div_acc;  // Divisor access active
	logic        ext_en;   // Extended fields enabled
	logic        wr_hit;   // Write decode helper
	logic [7:0]  ie_vis;   // Visible interrupt enable
	logic [7:0]  fc_vis;   // Visible fifo control
	logic [7:0]  mc_vis;   // Visible modem control
	logic [3:0]  dl_vis;   // Visible delay
	logic [EV_W-1:0] ev_set; // Event set terms

	// ----------------------------------------
	// Visible and effective values
	// ----------------------------------------
	assign div_acc = st.line_ctl[LC_DIV_BIT];
	assign ext_en  = st.enh[EF_EN_BIT];
	// Gated bits read as zero and reach cfg as zero while disabled
	assign ie_vis  = ext_en ? st.int_en : (st.int_en & ~IE_EXT);       // RQ3
	assign fc_vis  = ext_en ? st.fifo_ctl : (st.fifo_ctl & ~FC_EXT);   // RQ4
	assign mc_vis  = ext_en ? st.modem_ctl : (st.modem_ctl & ~MC_EXT); // RQ4
	assign dl_vis  = ext_en ? st.delay : RST_NIB;                      // RQ4

	// Strobes toward the core
	assign rx_pop  = rd && (addr == OFS_DATA) && !div_acc; // RQ2
	assign tx_load = wr && (addr == OFS_DATA) && !div_acc; // RQ2
	assign wr_hit  = wr;

	// General outs only enter the loopback path, never a pin
	assign loop_general = st.modem_ctl[MC_LOOP] ?
		{st.modem_ctl[MC_GOB], st.modem_ctl[MC_GOA]} : 2'h0; // RQ5 RQ6

	// Event set terms
	always_comb begin
		ev_set = RST_EV;
		ev_set[EV_PAUSE]  = core.xoff_seen;
		ev_set[EV_RESUME] = core.xon_seen;
		ev_set[EV_TXLOAD] = tx_load;
		ev_set[EV_DIV]    = wr_hit && div_acc &&
			((addr == OFS_DATA) || (addr == OFS_IE));
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// Writes
		if (wr) begin
			unique case (addr)
				OFS_DATA: begin
					if (div_acc) begin
						next_st.div_low = wdata; // RQ1
					end else begin
						next_st.tx_hold = wdata; // RQ2
					end
				end
				OFS_IE: begin
					if (div_acc) begin
						next_st.div_high = wdata; // RQ1
					end else if (ext_en) begin
						next_st.int_en = wdata; // RQ2
					end else begin
						// Gated bits keep their value
						next_st.int_en = (st.int_en & IE_EXT) | (wdata & ~IE_EXT); // RQ3
					end
				end
				OFS_ISRC: begin
					if (ext_en) begin
						next_st.fifo_ctl = wdata;
					end else begin
						next_st.fifo_ctl = (st.fifo_ctl & FC_EXT) | (wdata & ~FC_EXT); // RQ4
					end
				end
				OFS_LINE: begin
					next_st.line_ctl = wdata;
				end
				OFS_MODEM: begin
					if (ext_en) begin
						next_st.modem_ctl = wdata; // RQ6
					end else begin
						next_st.modem_ctl = (st.modem_ctl & MC_EXT) | (wdata & ~MC_EXT); // RQ6
					end
				end
				OFS_MSTAT: begin
					// Low nibble ignored
					if (ext_en) begin
						next_st.delay = wdata[7:4]; // RQ11
					end
				end
				OFS_SCR: begin
					next_st.scratch = wdata; // RQ12
				end
				OFS_FEAT: begin
					next_st.feat = wdata;
				end
				OFS_ENH: begin
					next_st.enh = wdata;
				end
				OFS_TXLV: begin
					next_st.tx_trg = wdata; // RQ9
				end
				OFS_RXLV: begin
					next_st.rx_trg = wdata; // RQ10
				end
				OFS_FLOW0: begin
					next_st.pause1 = wdata; // RQ8
				end
				OFS_FLOW1: begin
					next_st.pause2 = wdata; // RQ8
				end
				OFS_FLOW2: begin
					next_st.resume1 = wdata; // RQ8
				end
				OFS_FLOW3: begin
					next_st.resume2 = wdata; // RQ8
				end
				OFS_MSK: begin
					next_st.msk = wdata[EV_W-1:0];
				end
				default: begin
					// Line status writes and unmapped ignored
				end
			endcase
		end
		// Read data, valid one cycle after the strobe
		next_st.rdata = RST_BYTE;
		if (rd) begin
			unique case (addr)
				OFS_DATA:  next_st.rdata = div_acc ? st.div_low : core.rx_char; // RQ1 RQ2
				OFS_IE:    next_st.rdata = div_acc ? st.div_high : ie_vis;      // RQ1 RQ3
				OFS_ISRC:  next_st.rdata = ext_en ? core.int_source :
					(core.int_source & ~IS_EXT); // RQ4
				OFS_LINE:  next_st.rdata = st.line_ctl;
				OFS_MODEM: next_st.rdata = mc_vis; // RQ6
				OFS_LSTAT: next_st.rdata = core.line_status;
				OFS_MSTAT: next_st.rdata = core.modem_status; // RQ11
				OFS_SCR:   next_st.rdata = st.scratch; // RQ12
				OFS_FEAT:  next_st.rdata = st.feat;
				OFS_ENH:   next_st.rdata = st.enh;
				OFS_TXLV:  next_st.rdata = core.tx_level; // RQ9
				OFS_RXLV:  next_st.rdata = core.rx_level; // RQ10
				OFS_FLOW0: next_st.rdata = {6'h00, st.flags}; // RQ7
				OFS_EVT:   next_st.rdata = {4'h0, st.evt};
				OFS_MSK:   next_st.rdata = {4'h0, st.msk};
				default:   next_st.rdata = RST_BYTE;
			endcase
		end
		// Flags clear on read, a new detection wins
		if (rd && (addr == OFS_FLOW0)) begin
			next_st.flags = 2'h0; // RQ7
		end
		if (core.xoff_seen) begin
			next_st.flags[FL_PAUSE] = 1'b1;
		end
		if (core.xon_seen) begin
			next_st.flags[FL_RESUME] = 1'b1;
		end
		// Sticky events, write one clears, set wins
		if (wr && (addr == OFS_EVT)) begin
			next_st.evt = st.evt & ~wdata[EV_W-1:0];
		end
		next_st.evt = next_st.evt | ev_set;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = st.rdata;
	assign irq   = |(st.evt & st.msk);
	always_comb begin
		cfg = '0;
		cfg.divisor           = {st.div_high, st.div_low};
		cfg.interrupt_enable  = ie_vis;
		cfg.fifo_control      = fc_vis;
		cfg.line_control      = st.line_ctl;
		cfg.modem_control     = mc_vis;
		cfg.turnaround        = dl_vis;
		cfg.feature_control   = st.feat;
		cfg.enhanced_function = st.enh;
		cfg.tx_trigger        = st.tx_trg;
		cfg.rx_trigger        = st.rx_trg;
		cfg.pause_first       = st.pause1;
		cfg.pause_second      = st.pause2;
		cfg.resume_first      = st.resume1;
		cfg.resume_second     = st.resume2;
		cfg.tx_char           = st.tx_hold;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	div_low_read_a: assert property ( // RQ1
		rd && addr == OFS_DATA && div_acc |=> rdata == $past(st.div_low))
		else $error("divisor low read wrong");
	rx_char_read_a: assert property ( // RQ2
		rd && addr == OFS_DATA && !div_acc |-> rx_pop ##1 rdata == $past(core.rx_char))
		else $error("rx char read wrong");
	ext_gate_ie_a: assert property ( // RQ3
		!ext_en |-> (cfg.interrupt_enable & IE_EXT) == 8'h00)
		else $error("gated enable bits active");
	ext_gate_mc_a: assert property ( // RQ4
		!ext_en |-> (cfg.modem_control & MC_EXT) == 8'h00 && cfg.turnaround == 4'h0)
		else $error("gated modem bits active");
	// Out b is never gated, out a only lands while extended fields are on
	general_store_a: assert property ( // RQ6
		wr && addr == OFS_MODEM |=> st.modem_ctl[MC_GOB] == $past(wdata[MC_GOB]) &&
		(!$past(ext_en) || st.modem_ctl[MC_GOA] == $past(wdata[MC_GOA])))
		else $error("general outs not stored");
	flag_clear_a: assert property ( // RQ7
		rd && addr == OFS_FLOW0 && !core.xon_seen && !core.xoff_seen |=> st.flags == 2'h0)
		else $error("flags not cleared");
	pause_write_a: assert property ( // RQ8
		wr && addr == OFS_FLOW0 && !rd && !core.xon_seen && !core.xoff_seen |=>
		cfg.pause_first == $past(wdata) && st.flags == $past(st.flags))
		else $error("pause write wrong");
	tx_level_read_a: assert property ( // RQ9
		rd && addr == OFS_TXLV |=> rdata == $past(core.tx_level))
		else $error("tx level read wrong");
	delay_write_a: assert property ( // RQ11
		wr && addr == OFS_MSTAT && ext_en |=> st.delay == $past(wdata[7:4]))
		else $error("delay write wrong");
	scratch_keep_a: assert property ( // RQ12
		wr && addr == OFS_SCR |=> st.scratch == $past(wdata))
		else $error("scratch not kept");
	scratch_read_a: assert property ( // RQ12
		rd && addr == OFS_SCR |=> rdata == $past(st.scratch))
		else $error("scratch read wrong");

	// ----------------------------------------
	// Divisor and holding checks
	// ----------------------------------------
	// A divisor byte must never look like a transmit load to the core
	div_high_read_a: assert property ( // RQ1
		rd && addr == OFS_IE && div_acc |=> rdata == $past(st.div_high))
		else $error("divisor high read wrong");
	div_write_a: assert property ( // RQ1
		wr && addr == OFS_DATA && div_acc |-> !tx_load ##1 st.div_low == $past(wdata))
		else $error("divisor low write wrong");
	tx_hold_write_a: assert property ( // RQ2
		wr && addr == OFS_DATA && !div_acc |-> tx_load ##1 cfg.tx_char == $past(wdata))
		else $error("tx holding write wrong");
	ie_write_a: assert property ( // RQ2
		wr && addr == OFS_IE && !div_acc && ext_en |=> st.int_en == $past(wdata))
		else $error("interrupt enable write wrong");

	// ----------------------------------------
	// Extended field gating checks
	// ----------------------------------------
	// Gated enables keep their stored value through a write while disabled
	ext_hold_ie_a: assert property ( // RQ3
		wr && addr == OFS_IE && !div_acc && !ext_en |=>
		(st.int_en & IE_EXT) == $past(st.int_en & IE_EXT))
		else $error("gated enables overwritten");
	ext_gate_fc_a: assert property ( // RQ4
		!ext_en |-> (cfg.fifo_control & FC_EXT) == 8'h00)
		else $error("gated fifo bits active");
	source_gate_a: assert property ( // RQ4
		rd && addr == OFS_ISRC && !ext_en |=> (rdata & IS_EXT) == 8'h00)
		else $error("gated source bits visible");
	delay_ignore_a: assert property ( // RQ11
		wr && addr == OFS_MSTAT && !ext_en |=> st.delay == $past(st.delay))
		else $error("delay written while disabled");
	modem_status_read_a: assert property ( // RQ11
		rd && addr == OFS_MSTAT |=> rdata == $past(core.modem_status))
		else $error("modem status read wrong");
	// Without loopback the general outs reach nothing at all
	loop_off_a: assert property ( // RQ5
		!st.modem_ctl[MC_LOOP] |-> loop_general == 2'h0)
		else $error("general outs leak");

	// ----------------------------------------
	// Flow character and fifo checks
	// ----------------------------------------
	flag_read_a: assert property ( // RQ7
		rd && addr == OFS_FLOW0 |=> rdata == {6'h00, $past(st.flags)})
		else $error("flag read wrong");
	// A detection in the read cycle keeps its flag
	resume_set_a: assert property ( // RQ7
		core.xon_seen |=> st.flags[FL_RESUME])
		else $error("resume flag lost");
	pause_set_a: assert property ( // RQ7
		core.xoff_seen |=> st.flags[FL_PAUSE])
		else $error("pause flag lost");
	resume_char_a: assert property ( // RQ8
		wr && addr == OFS_FLOW3 |=> cfg.resume_second == $past(wdata))
		else $error("resume char write wrong");
	tx_trig_write_a: assert property ( // RQ9
		wr && addr == OFS_TXLV |=> cfg.tx_trigger == $past(wdata))
		else $error("tx trigger write wrong");
	rx_level_read_a: assert property ( // RQ10
		rd && addr == OFS_RXLV |=> rdata == $past(core.rx_level))
		else $error("rx level read wrong");
	rx_trig_write_a: assert property ( // RQ10
		wr && addr == OFS_RXLV |=> cfg.rx_trigger == $past(wdata))
		else $error("rx trigger write wrong");

endmodule

// ### tb/ucrm_core_model.sv
// Behavioural model of the serial core that feeds the register map
`timescale 1ns/1ps
module ucrm_core_model
	import ucrm_pkg::*;
#(
	parameter logic [7:0] RX_CHAR = 8'h3c, // Received character
	parameter logic [7:0] ISRC    = 8'hff, // Interrupt source
	parameter logic [7:0] LSTAT   = 8'h61, // Line status
	parameter logic [7:0] MSTAT   = 8'hb0, // Modem status
	parameter logic [7:0] TX_LVL  = 8'h11, // Tx fifo fill
	parameter logic [7:0] RX_LVL  = 8'h22  // Rx fifo fill
) (
	input  wire logic       clk,        // Device clock
	input  wire logic       rstn,       // Async reset, active low
	input  wire logic       pause_req,  // Request a pause char detection
	input  wire logic       resume_req, // Request a resume char detection
	output ucrm_pkg::ucrm_core_t core   // Status towards the register map
);
	logic [1:0] seen; // Detection pulses, one cycle each

	// ----------------------------------------
	// Detection pulses
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seen <= 2'h0;
		end else begin
			seen <= {resume_req, pause_req};
		end
	end

	// ----------------------------------------
	// Status levels
	// ----------------------------------------
	always_comb begin
		core.rx_char      = RX_CHAR;
		core.int_source   = ISRC;
		core.line_status  = LSTAT;
		core.modem_status = MSTAT;
		core.tx_level     = TX_LVL;
		core.rx_level     = RX_LVL;
		core.xon_seen     = seen[1];
		core.xoff_seen    = seen[0];
	end
endmodule

// ### tb/uart_channel_register_map_bench.sv
// Self-checking bench of the channel register map
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); end end
module uart_channel_register_map_bench;
	import ucrm_pkg::*;
	logic              clk = 1'b0;    // Device clock
	logic              rstn = 1'b0;   // Reset, active low
	logic [4:0]        addr = 5'h00;  // Register address
	logic [7:0]        wdata = 8'h00; // Write data
	logic              wr = 1'b0;     // Write strobe
	logic              rd = 1'b0;     // Read strobe
	logic [7:0]        rdata;         // Read data
	ucrm_core_t        core;          // Core status
	ucrm_cfg_t         cfg;           // Configuration out
	logic              rx_pop;        // Rx read pulse
	logic              tx_load;       // Tx load pulse
	logic [1:0]        loop_general;  // General outs into loopback
	logic              irq;           // Interrupt level
	logic              pause_req = 1'b0;  // Pause detection request
	logic              resume_req = 1'b0; // Resume detection request
	int                n_fail = 0;        // Mismatches
	int                samples_checked = 0; // Comparisons
	int                loads = 0;         // Tx load pulses seen
	int                nload;             // Snapshot of loads
	int                pops = 0;          // Rx pop pulses seen
	int                npop;              // Snapshot of pops

	always #5 clk = ~clk;
	always @(posedge clk) if (tx_load === 1'b1) loads++;
	always @(posedge clk) if (rx_pop === 1'b1) pops++;

	ucrm_regs u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .core(core), .cfg(cfg), .rx_pop(rx_pop), .tx_load(tx_load),
		.loop_general(loop_general), .irq(irq));
	ucrm_core_model u_core (.clk(clk), .rstn(rstn), .pause_req(pause_req),
		.resume_req(resume_req), .core(core));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e, "read data")
	endtask
	task automatic detect(input logic p, input logic r);
		@(posedge clk);
		pause_req <= p; resume_req <= r;
		@(posedge clk);
		pause_req <= 1'b0; resume_req <= 1'b0;
	endtask
	task automatic test_end(input string name);
		$display("test %s done, failures so far %0d", name, n_fail);
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(OFS_SCR, 8'h00);
		rd_reg(OFS_LINE, 8'h00);
		rd_reg(5'h15, 8'h00);
		wr_reg(OFS_SCR, 8'ha5);
		rd_reg(OFS_SCR, 8'ha5);
		wr_reg(OFS_SCR, 8'h5a);
		rd_reg(OFS_SCR, 8'h5a);
		wr_reg(OFS_FEAT, 8'h5c);
		rd_reg(OFS_FEAT, 8'h5c);
		`CHK(cfg.feature_control, 8'h5c, "feature")
		test_end("reset_scratch");
		// Divisor access and holding registers
		wr_reg(OFS_LINE, 8'h83);
		`CHK(cfg.line_control, 8'h83, "line control")
		nload = loads;
		npop = pops;
		wr_reg(OFS_DATA, 8'h34);
		wr_reg(OFS_IE, 8'h12);
		`CHK(cfg.divisor, 16'h1234, "divisor")
		rd_reg(OFS_DATA, 8'h34);
		rd_reg(OFS_IE, 8'h12);
		`CHK(loads, nload, "no tx load")
		`CHK(pops, npop, "no rx pop")
		wr_reg(OFS_LINE, 8'h03);
		wr_reg(OFS_DATA, 8'h55);
		`CHK(cfg.tx_char, 8'h55, "tx char")
		`CHK(loads, nload + 1, "tx load")
		rd_reg(OFS_DATA, 8'h3c);
		`CHK(pops, npop + 1, "rx pop")
		`CHK(cfg.divisor, 16'h1234, "divisor kept")
		test_end("divisor");
		// Gated fields while enhanced mode is off, then on
		wr_reg(OFS_IE, 8'hff);
		rd_reg(OFS_IE, 8'h1f);
		wr_reg(OFS_MODEM, 8'hff);
		rd_reg(OFS_MODEM, 8'h1b);
		`CHK(cfg.modem_control, 8'h1b, "modem gated")
		rd_reg(OFS_ISRC, 8'hcf);
		wr_reg(OFS_ENH, 8'h10);
		rd_reg(OFS_ENH, 8'h10);
		`CHK(cfg.enhanced_function, 8'h10, "enhanced")
		wr_reg(OFS_IE, 8'hff);
		rd_reg(OFS_IE, 8'hff);
		wr_reg(OFS_ISRC, 8'hff);
		`CHK(cfg.fifo_control, 8'hff, "fifo control")
		rd_reg(OFS_ISRC, 8'hff);
		wr_reg(OFS_MODEM, 8'hff);
		rd_reg(OFS_MODEM, 8'hff);
		wr_reg(OFS_MSTAT, 8'ha7);
		`CHK(cfg.turnaround, 4'ha, "turnaround")
		rd_reg(OFS_MSTAT, 8'hb0);
		`CHK(loop_general, 2'b11, "loop outs")
		wr_reg(OFS_MODEM, 8'h18);
		`CHK(loop_general, 2'b10, "loop out b")
		wr_reg(OFS_MODEM, 8'h14);
		`CHK(loop_general, 2'b01, "loop out a")
		wr_reg(OFS_MODEM, 8'h0c);
		`CHK(loop_general, 2'b00, "no loopback")
		wr_reg(OFS_ENH, 8'h00);
		`CHK(cfg.interrupt_enable, 8'h1f, "enables gated")
		`CHK(cfg.fifo_control, 8'hcf, "fifo gated")
		`CHK(cfg.turnaround, 4'h0, "delay gated")
		wr_reg(OFS_LSTAT, 8'h00);
		rd_reg(OFS_LSTAT, 8'h61);
		test_end("enhanced");
		// Fifo triggers and levels
		wr_reg(OFS_TXLV, 8'h40);
		wr_reg(OFS_RXLV, 8'h20);
		`CHK({cfg.tx_trigger, cfg.rx_trigger}, 16'h4020, "triggers")
		rd_reg(OFS_TXLV, 8'h11);
		rd_reg(OFS_RXLV, 8'h22);
		test_end("fifo");
		// Flow characters and flags
		for (int i = 0; i < 4; i++) wr_reg(OFS_FLOW0 + 5'(i), 8'hc0 + 8'(i));
		`CHK({cfg.pause_first, cfg.pause_second, cfg.resume_first, cfg.resume_second},
			32'hc0c1c2c3, "flow chars")
		wr_reg(OFS_EVT, 8'h0f);
		detect(1'b0, 1'b1);
		rd_reg(OFS_FLOW0, 8'h02);
		rd_reg(OFS_FLOW0, 8'h00);
		detect(1'b1, 1'b1);
		rd_reg(OFS_FLOW0, 8'h03);
		detect(1'b1, 1'b0);
		wr_reg(OFS_FLOW0, 8'h99);
		rd_reg(OFS_FLOW0, 8'h01);
		`CHK(cfg.pause_first, 8'h99, "pause char")
		test_end("flow");
		// Event status, mask and interrupt
		wr_reg(OFS_EVT, 8'h0f);
		detect(1'b1, 1'b0);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b0, "masked")
		rd_reg(OFS_EVT, 8'h01);
		wr_reg(OFS_MSK, 8'h01);
		`CHK(irq, 1'b1, "raised")
		rd_reg(OFS_MSK, 8'h01);
		wr_reg(OFS_EVT, 8'h01);
		`CHK(irq, 1'b0, "cleared")
		test_end("interrupt");
		// Mid-run reset with an interrupt pending
		detect(1'b1, 1'b0);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b1, "raised again")
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		`CHK(cfg, '0, "cfg reset")
		`CHK(irq, 1'b0, "irq reset")
		`CHK(loop_general, 2'h0, "loop reset")
		`CHK(rdata, 8'h00, "rdata reset")
		rd_reg(OFS_SCR, 8'h00);
		rd_reg(OFS_MSK, 8'h00);
		test_end("reset");
		close_out();
	end
endmodule
